// ==== src/crf_defs.svh ====
`ifndef CRF_DEFS_SVH
`define CRF_DEFS_SVH

// ----------------------------------------------------------------
// Flag register bit positions
// ----------------------------------------------------------------
`define CRF_I_BIT 7
`define CRF_U_BIT 6
`define CRF_H_BIT 5
`define CRF_N_BIT 3
`define CRF_Z_BIT 2
`define CRF_V_BIT 1
`define CRF_C_BIT 0
`define CRF_FLAGS_RST 8'h80

// ----------------------------------------------------------------
// Register views
// ----------------------------------------------------------------
`define CRF_LONG_W 32
`define CRF_WORD_W 16
`define CRF_BYTE_W 8
`define CRF_REGS 8
`define CRF_SP_IDX 3'h7
`define CRF_REG_RST 32'h0000_0000

// ----------------------------------------------------------------
// Arithmetic carry taps: sign bit and the bit above the nibble carry
// ----------------------------------------------------------------
`define CRF_B_MSB 7
`define CRF_W_MSB 15
`define CRF_L_MSB 31
`define CRF_B_HC 4
`define CRF_W_HC 12
`define CRF_L_HC 28
`define CRF_B_MASK 32'h0000_00ff
`define CRF_W_MASK 32'h0000_ffff
`define CRF_L_MASK 32'hffff_ffff

// ----------------------------------------------------------------
// Program counter and stack
// ----------------------------------------------------------------
`define CRF_PC_W 24
`define CRF_PC_RST 24'h00_0000
`define CRF_PC_STEP 24'h00_0002
`define CRF_ADDR_W 16
`define CRF_SP_W_STEP 32'h0000_0002
`define CRF_SP_L_STEP 32'h0000_0004

`endif

// ==== src/crf_pkg.sv ====
package crf_pkg;

    typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} crf_size_t;

    typedef enum logic [2:0] {
        ALU_ADD, ALU_ADDX, ALU_SUB, ALU_SUBX, ALU_CMP, ALU_NEG, ALU_LOGIC
    } crf_alu_kind_t;

    typedef enum logic [2:0] {FL_NONE, FL_LOAD, FL_AND, FL_OR, FL_XOR, FL_ARITH} crf_flag_op_t;

    typedef enum logic [2:0] {SP_HOLD, SP_PUSH_W, SP_PUSH_L, SP_POP_W, SP_POP_L} crf_sp_cmd_t;

    typedef enum logic [1:0] {PC_HOLD, PC_STEP, PC_JUMP, PC_VEC} crf_pc_cmd_t;

    typedef enum logic [3:0] {
        BR_ALWAYS, BR_NEVER, BR_HI, BR_LS, BR_CC, BR_CS, BR_NE, BR_EQ,
        BR_VC, BR_VS, BR_PL, BR_MI, BR_GE, BR_LT, BR_GT, BR_LE
    } crf_br_cond_t;

    // Register view: index, width, part (1 = upper word / high byte)
    typedef struct packed {
        logic [2:0] idx;
        crf_size_t size;
        logic part;
    } crf_sel_t;

    typedef struct packed {
        logic en;
        crf_sel_t sel;
        logic [31:0] data;
    } crf_wr_t;

    typedef struct packed {
        crf_alu_kind_t kind;
        crf_size_t size;
        logic [31:0] a;
        logic [31:0] b;
    } crf_alu_t;

    typedef struct packed {
        crf_flag_op_t op;
        logic [7:0] imm;
        logic [7:0] upd;
    } crf_flag_req_t;

endpackage

// ==== src/crf_flag_calc.sv ====
`timescale 1ns/1ps
`include "crf_defs.svh"

module crf_flag_calc (
    input wire logic [31:0] op_a,
    input wire logic [31:0] op_b,
    input wire logic carry_in,
    input wire crf_pkg::crf_size_t size,
    input wire crf_pkg::crf_alu_kind_t kind,
    output logic [31:0] result,
    output logic [7:0] flags
);
    import crf_pkg::*;

    wire logic is_neg = (kind == ALU_NEG);
    wire logic is_sub = (kind == ALU_SUB) || (kind == ALU_SUBX) || (kind == ALU_CMP) || is_neg;
    wire logic is_logic = (kind == ALU_LOGIC);
    wire logic [31:0] x = is_neg ? `CRF_REG_RST : op_a;
    wire logic [31:0] y_raw = is_neg ? op_a : op_b;
    wire logic [31:0] y = is_sub ? ~y_raw : y_raw;
    wire logic ci = (kind == ALU_ADDX) ? carry_in : (kind == ALU_SUBX) ? ~carry_in : is_sub;
    wire logic [32:0] sum = {1'b0, x} + {1'b0, y} + {32'h0000_0000, ci};
    // Carry into each bit position, bit 32 is the carry out of the long word
    wire logic [32:0] cin_vec = sum ^ {1'b0, x} ^ {1'b0, y};

    logic [31:0] mask;
    logic [5:0] msb;
    logic [5:0] hc;
    logic [31:0] res_m;

    always_comb begin
        case (size)
            SZ_BYTE: begin
                mask = `CRF_B_MASK;
                msb = 6'(`CRF_B_MSB);
                hc = 6'(`CRF_B_HC);
            end
            SZ_WORD: begin
                mask = `CRF_W_MASK;
                msb = 6'(`CRF_W_MSB);
                hc = 6'(`CRF_W_HC);
            end
            default: begin
                mask = `CRF_L_MASK;
                msb = 6'(`CRF_L_MSB);
                hc = 6'(`CRF_L_HC);
            end
        endcase
    end

    assign result = is_logic ? op_a : sum[31:0];
    assign res_m = result & mask;

    always_comb begin
        flags = 8'h00;
        flags[`CRF_N_BIT] = res_m[msb[4:0]];
        flags[`CRF_Z_BIT] = (res_m == `CRF_REG_RST);
        if (!is_logic) begin
            flags[`CRF_V_BIT] = cin_vec[msb + 6'h01] ^ cin_vec[msb];
            flags[`CRF_C_BIT] = cin_vec[msb + 6'h01] ^ is_sub;
            flags[`CRF_H_BIT] = cin_vec[hc] ^ is_sub;
        end
    end

endmodule // crf_flag_calc

// ==== src/crf_regset.sv ====
// Behaviour
// [RULE1] Eight identical 32-bit general registers, usable for addresses or data.
// [RULE2] Each register splits into independent upper and lower 16-bit halves.
// [RULE3] Each lower half splits into independent high and low bytes.
// [RULE4] Every register may be used at any width, independent of the others.
// [RULE5] Register seven doubles as stack pointer for exceptions and calls.
// [RULE6] A 24-bit program counter holds the next instruction address.
// [RULE7] Fetch address always has its least significant bit forced to zero.
// [RULE8] Reset exception loads the program counter from the vector fetch.
// [RULE9] Reset sets the interrupt mask to one; other flags undefined.
// [RULE10] Mask set blocks ordinary interrupts; unmaskable request always accepted.
// [RULE11] Every exception sequence start sets the interrupt mask to one.
// [RULE12] Bit six is a user flag with no hardware effect.
// [RULE13] Byte add, subtract, compare, negate: nibble carry from bit three.
// [RULE14] Word add, subtract, compare, negate: nibble carry from bit eleven.
// [RULE15] Long add, subtract, compare, negate: nibble carry from bit twenty-seven.
// [RULE16] Flags loadable, storable, AND, OR, XOR; some instructions keep flags.
// [RULE17] Branch conditions use sign, zero, overflow and carry flags.
// [RULE18] Only normal mode: addresses limited to a 64-kbyte space.
// [RULE19] Sign flag takes the result's most significant bit.
// [RULE20] Zero flag is one for a zero result, else zero.
// [RULE21] Overflow flag is one on arithmetic overflow, else zero.
// [RULE22] Carry flag is carry for add and shift, borrow for subtract.
// [RULE23] Narrow writes change only the selected bits of the register.
// [RULE24] Flag updates land at instruction end; next instruction sees them.
`timescale 1ns/1ps
`include "crf_defs.svh"

module crf_regset (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire crf_pkg::crf_wr_t wr,
    input wire crf_pkg::crf_sel_t rd_a_sel,
    input wire crf_pkg::crf_sel_t rd_b_sel,
    input wire crf_pkg::crf_sp_cmd_t sp_cmd,
    input wire crf_pkg::crf_pc_cmd_t pc_cmd,
    input wire logic [23:0] pc_val,
    input wire logic exc_start,
    input wire crf_pkg::crf_alu_t alu,
    input wire crf_pkg::crf_flag_req_t flag_req,
    input wire crf_pkg::crf_br_cond_t br_cond,
    input wire logic irq_req,
    input wire logic nmi_req,
    output logic [31:0] rd_a_q,
    output logic [31:0] rd_b_q,
    output logic [31:0] sp_q,
    output logic [23:0] pc_q,
    output logic [15:0] fetch_addr_q,
    output logic [15:0] sp_addr_q,
    output logic [7:0] flags_q,
    output logic [31:0] alu_res_q,
    output logic br_taken_q,
    output logic irq_take_q,
    output logic nmi_take_q
);
    import crf_pkg::*;

    // ----------------------------------------------------------------
    // View helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] merge_view(input logic [31:0] old, input crf_sel_t s,
                                               input logic [31:0] d);
        logic [31:0] n;
        n = old;
        case (s.size)
            SZ_LONG: n = d;
            SZ_WORD: begin
                if (s.part) begin
                    n[`CRF_WORD_W +: `CRF_WORD_W] = d[0 +: `CRF_WORD_W];
                end else begin
                    n[0 +: `CRF_WORD_W] = d[0 +: `CRF_WORD_W];
                end
            end
            SZ_BYTE: begin
                if (s.part) begin
                    n[`CRF_BYTE_W +: `CRF_BYTE_W] = d[0 +: `CRF_BYTE_W];
                end else begin
                    n[0 +: `CRF_BYTE_W] = d[0 +: `CRF_BYTE_W];
                end
            end
            default: n = old;
        endcase
        return n;
    endfunction

    function automatic logic [31:0] read_view(input logic [31:0] r, input crf_sel_t s);
        logic [31:0] v;
        v = `CRF_REG_RST;
        case (s.size)
            SZ_LONG: v = r;
            SZ_WORD: begin
                if (s.part) begin
                    v[0 +: `CRF_WORD_W] = r[`CRF_WORD_W +: `CRF_WORD_W];
                end else begin
                    v[0 +: `CRF_WORD_W] = r[0 +: `CRF_WORD_W];
                end
            end
            SZ_BYTE: begin
                if (s.part) begin
                    v[0 +: `CRF_BYTE_W] = r[`CRF_BYTE_W +: `CRF_BYTE_W];
                end else begin
                    v[0 +: `CRF_BYTE_W] = r[0 +: `CRF_BYTE_W];
                end
            end
            default: v = `CRF_REG_RST;
        endcase
        return v;
    endfunction

    // ----------------------------------------------------------------
    // General registers
    // ----------------------------------------------------------------
    logic [31:0] regs_q [`CRF_REGS];
    logic [31:0] regs_d [`CRF_REGS];
    logic [31:0] sp_next;

    wire logic [31:0] sp_cur = regs_q[`CRF_SP_IDX];

    always_comb begin
        case (sp_cmd)
            SP_PUSH_W: sp_next = sp_cur - `CRF_SP_W_STEP; // RULE5
            SP_PUSH_L: sp_next = sp_cur - `CRF_SP_L_STEP; // RULE5
            SP_POP_W: sp_next = sp_cur + `CRF_SP_W_STEP; // RULE5
            SP_POP_L: sp_next = sp_cur + `CRF_SP_L_STEP; // RULE5
            default: sp_next = sp_cur;
        endcase
    end

    // An explicit write to register seven wins over an implicit stack step
    for (genvar i = 0; i < `CRF_REGS; i++) begin : g_reg
        wire logic hit = wr.en && (wr.sel.idx == 3'(i)); // RULE1
        assign regs_d[i] = hit ? merge_view(regs_q[i], wr.sel, wr.data) : // RULE2 RULE3 RULE4 RULE23
                           (3'(i) == `CRF_SP_IDX) ? sp_next : regs_q[i]; // RULE5

        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
                regs_q[i] <= `CRF_REG_RST;
            end else begin
                regs_q[i] <= regs_d[i];
            end
        end
    end

    // Read ports: the view of the selected register, one cycle later
    wire logic [31:0] rd_a_d = read_view(regs_q[rd_a_sel.idx], rd_a_sel); // RULE2 RULE3
    wire logic [31:0] rd_b_d = read_view(regs_q[rd_b_sel.idx], rd_b_sel); // RULE4

    // ----------------------------------------------------------------
    // Program counter
    // ----------------------------------------------------------------
    logic [23:0] pc_d;

    always_comb begin
        case (pc_cmd)
            PC_STEP: pc_d = pc_q + `CRF_PC_STEP; // RULE6
            PC_JUMP: pc_d = pc_val; // RULE6
            PC_VEC: pc_d = pc_val; // RULE8
            default: pc_d = pc_q;
        endcase
    end

    // Stored bit zero is kept but never used for fetching
    wire logic [15:0] fetch_d = {pc_d[`CRF_ADDR_W - 1:1], 1'b0}; // RULE7 RULE18

    // ----------------------------------------------------------------
    // Flags
    // ----------------------------------------------------------------
    logic [31:0] calc_res;
    logic [7:0] calc_flags;

    crf_flag_calc crf_flag_calc_i (
        .op_a(alu.a),
        .op_b(alu.b),
        .carry_in(flags_q[`CRF_C_BIT]),
        .size(alu.size),
        .kind(alu.kind),
        .result(calc_res),
        .flags(calc_flags)
    );

    // Bits outside upd keep their value, so an instruction may leave flags alone
    wire logic [7:0] upd_m = flag_req.upd & ~((8'h01 << `CRF_I_BIT) | (8'h01 << `CRF_U_BIT)); // RULE12
    wire logic [7:0] arith_d = (flags_q & ~upd_m) | (calc_flags & upd_m); // RULE13 RULE14 RULE15

    logic [7:0] op_d;

    always_comb begin
        case (flag_req.op)
            FL_LOAD: op_d = flag_req.imm; // RULE16 RULE12
            FL_AND: op_d = flags_q & flag_req.imm; // RULE16
            FL_OR: op_d = flags_q | flag_req.imm; // RULE16
            FL_XOR: op_d = flags_q ^ flag_req.imm; // RULE16
            FL_ARITH: op_d = arith_d; // RULE19 RULE20 RULE21 RULE22
            default: op_d = flags_q;
        endcase
    end

    // Exception start overrides the mask bit of any same-cycle update
    wire logic [7:0] flags_d = exc_start ? (op_d | (8'h01 << `CRF_I_BIT)) : op_d; // RULE11

    // ----------------------------------------------------------------
    // Branch conditions and interrupt gating
    // ----------------------------------------------------------------
    wire logic fn = flags_q[`CRF_N_BIT];
    wire logic fz = flags_q[`CRF_Z_BIT];
    wire logic fv = flags_q[`CRF_V_BIT];
    wire logic fc = flags_q[`CRF_C_BIT];
    logic br_d;

    always_comb begin
        case (br_cond)
            BR_ALWAYS: br_d = 1'b1;
            BR_NEVER: br_d = 1'b0;
            BR_HI: br_d = !(fc || fz); // RULE17
            BR_LS: br_d = fc || fz; // RULE17
            BR_CC: br_d = !fc; // RULE17
            BR_CS: br_d = fc; // RULE17
            BR_NE: br_d = !fz; // RULE17
            BR_EQ: br_d = fz; // RULE17
            BR_VC: br_d = !fv; // RULE17
            BR_VS: br_d = fv; // RULE17
            BR_PL: br_d = !fn; // RULE17
            BR_MI: br_d = fn; // RULE17
            BR_GE: br_d = !(fn ^ fv); // RULE17
            BR_LT: br_d = fn ^ fv; // RULE17
            BR_GT: br_d = !(fz || (fn ^ fv)); // RULE17
            BR_LE: br_d = fz || (fn ^ fv); // RULE17
            default: br_d = 1'b0;
        endcase
    end

    wire logic irq_d = irq_req && !flags_q[`CRF_I_BIT]; // RULE10

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pc_q <= `CRF_PC_RST;
            fetch_addr_q <= `CRF_ADDR_W'(`CRF_PC_RST);
            flags_q <= `CRF_FLAGS_RST; // RULE9
        end else begin
            pc_q <= pc_d;
            fetch_addr_q <= fetch_d; // RULE7
            flags_q <= flags_d; // RULE24
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_a_q <= `CRF_REG_RST;
            rd_b_q <= `CRF_REG_RST;
            sp_q <= `CRF_REG_RST;
            sp_addr_q <= `CRF_ADDR_W'(`CRF_REG_RST);
            alu_res_q <= `CRF_REG_RST;
        end else begin
            rd_a_q <= rd_a_d;
            rd_b_q <= rd_b_d;
            sp_q <= regs_d[`CRF_SP_IDX]; // RULE5
            sp_addr_q <= regs_d[`CRF_SP_IDX][`CRF_ADDR_W - 1:0]; // RULE18
            alu_res_q <= calc_res;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            br_taken_q <= 1'b0;
            irq_take_q <= 1'b0;
            nmi_take_q <= 1'b0;
        end else begin
            br_taken_q <= br_d;
            irq_take_q <= irq_d;
            nmi_take_q <= nmi_req; // RULE10
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    AST_FETCH_EVEN: assert property (fetch_addr_q[0] == 1'b0 && fetch_addr_q[15:1] == pc_q[15:1]) // RULE7
        else $error("fetch address not even copy of pc");

    AST_EXC_MASK: assert property (exc_start |=> flags_q[`CRF_I_BIT]) // RULE11
        else $error("mask bit not set after exception start");

    AST_IRQ_BLOCK: assert property (irq_req && flags_q[`CRF_I_BIT] |=> !irq_take_q) // RULE10
        else $error("interrupt taken while masked");

    AST_IRQ_OPEN: assert property (irq_req && !flags_q[`CRF_I_BIT] |=> irq_take_q) // RULE10
        else $error("open interrupt not taken");

    AST_NMI_TAKE: assert property (nmi_req |=> nmi_take_q) // RULE10
        else $error("unmaskable request not taken");

    AST_BYTE_KEEP: assert property (wr.en && wr.sel.size == SZ_BYTE && !wr.sel.part // RULE23
        && wr.sel.idx != `CRF_SP_IDX |=> regs_q[$past(wr.sel.idx)][31:8] == $past(regs_q[wr.sel.idx][31:8]))
        else $error("byte write disturbed upper bits");

    AST_SP_WRITE: assert property (wr.en && wr.sel.idx == `CRF_SP_IDX && wr.sel.size == SZ_LONG // RULE5
        |=> sp_q == $past(wr.data))
        else $error("stack write lost");

    AST_PC_VEC: assert property (pc_cmd == PC_VEC |=> pc_q == $past(pc_val)) // RULE8
        else $error("pc not loaded from vector");

    AST_PC_STEP: assert property (pc_cmd == PC_STEP |=> pc_q == $past(pc_q) + `CRF_PC_STEP) // RULE6
        else $error("pc step wrong");

    AST_ZERO_FLAG: assert property (flag_req.op == FL_ARITH && flag_req.upd[`CRF_Z_BIT] // RULE20
        |=> flags_q[`CRF_Z_BIT] == ($past(calc_res & (alu.size == SZ_BYTE ? `CRF_B_MASK :
            alu.size == SZ_WORD ? `CRF_W_MASK : `CRF_L_MASK)) == `CRF_REG_RST))
        else $error("zero flag wrong");

    AST_USER_KEEP: assert property (flag_req.op == FL_ARITH // RULE12
        |=> flags_q[`CRF_U_BIT] == $past(flags_q[`CRF_U_BIT]))
        else $error("user bit changed by arithmetic");

    AST_FLAG_LOAD: assert property (flag_req.op == FL_LOAD && !exc_start |=> flags_q == $past(flag_req.imm)) // RULE16
        else $error("flag load mismatch");

    AST_BR_EQ: assert property (br_cond == BR_EQ |=> br_taken_q == $past(fz)) // RULE17
        else $error("equal branch wrong");

    AST_SP_PUSH: assert property (sp_cmd == SP_PUSH_L && !(wr.en && wr.sel.idx == `CRF_SP_IDX)  // RULE5
        |=> sp_q == $past(sp_cur) - `CRF_SP_L_STEP ##1 sp_q == regs_q[`CRF_SP_IDX])
        else $error("stack push wrong");

    AST_FLAG_KEEP: assert property (flag_req.op == FL_NONE && !exc_start |=> $stable(flags_q)) // RULE24
        else $error("flags changed with no update");

    // ----------------------------------------------------------------
    // Coverage
    // ----------------------------------------------------------------
    COV_EXC: cover property (exc_start ##1 irq_req && !irq_take_q);
    COV_BYTE_HI: cover property (wr.en && wr.sel.size == SZ_BYTE && wr.sel.part);
    COV_ARITH_SUB: cover property (flag_req.op == FL_ARITH && alu.kind == ALU_SUB ##1 br_cond == BR_LT);
    COV_PC_VEC: cover property (pc_cmd == PC_VEC);

endmodule // crf_regset

// ==== verif/crf_core_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Sequencer stand-in: one instruction step per clock
// ----------------------------------------------------------------
module crf_core_model (
    input wire logic sys_clk,
    output wire crf_pkg::crf_wr_t wr,
    output wire crf_pkg::crf_sel_t rd_a_sel,
    output wire crf_pkg::crf_sel_t rd_b_sel,
    output wire crf_pkg::crf_sp_cmd_t sp_cmd,
    output wire crf_pkg::crf_pc_cmd_t pc_cmd,
    output wire logic [23:0] pc_val,
    output wire logic exc_start,
    output wire crf_pkg::crf_alu_t alu,
    output wire crf_pkg::crf_flag_req_t flag_req,
    output wire crf_pkg::crf_br_cond_t br_cond,
    output wire logic irq_req,
    output wire logic nmi_req
);
    import crf_pkg::*;
    typedef struct packed {
        crf_wr_t wr;
        crf_sel_t ra;
        crf_sel_t rb;
        crf_sp_cmd_t sp;
        crf_pc_cmd_t pc;
        logic [23:0] pv;
        logic exc;
        crf_alu_t alu;
        crf_flag_req_t fr;
        crf_br_cond_t br;
        logic irq;
        logic nmi;
    } crf_drive_t;
    crf_drive_t nx = '0;
    crf_drive_t cur = '0;
    assign {wr, rd_a_sel, rd_b_sel, sp_cmd, pc_cmd, pc_val, exc_start, alu, flag_req, br_cond, irq_req, nmi_req} = cur;
    // Launch on the falling edge, hold until the next step, which starts from an idle nx
    task automatic step();
        @(negedge sys_clk);
        cur <= nx;
        nx = '0;
        @(posedge sys_clk);
        #1;
    endtask
endmodule // crf_core_model

// ==== verif/test_cpu_register_set_and_flags.sv ====
`timescale 1ns/1ps
`include "crf_defs.svh"

module test_cpu_register_set_and_flags;
    import crf_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    crf_wr_t wr;
    crf_sel_t rd_a_sel, rd_b_sel, s, t;
    crf_sp_cmd_t sp_cmd;
    crf_pc_cmd_t pc_cmd;
    logic [23:0] pc_val, pc_q, pc_e;
    logic exc_start, irq_req, nmi_req, br_taken_q, irq_take_q, nmi_take_q;
    crf_alu_t alu, al;
    crf_flag_req_t flag_req;
    crf_br_cond_t br_cond;
    logic [31:0] rd_a_q, rd_b_q, sp_q, alu_res_q, d;
    logic [15:0] fetch_addr_q, sp_addr_q;
    logic [7:0] flags_q, fl, e;
    logic [31:0] regs [8];
    int errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int k;

    crf_core_model crf_core_model_i (.sys_clk, .wr, .rd_a_sel, .rd_b_sel, .sp_cmd, .pc_cmd, .pc_val, .exc_start,
        .alu, .flag_req, .br_cond, .irq_req, .nmi_req);
    crf_regset crf_regset_i (.sys_clk, .rstn, .wr, .rd_a_sel, .rd_b_sel, .sp_cmd, .pc_cmd, .pc_val, .exc_start,
        .alu, .flag_req, .br_cond, .irq_req, .nmi_req, .rd_a_q, .rd_b_q, .sp_q, .pc_q, .fetch_addr_q, .sp_addr_q,
        .flags_q, .alu_res_q, .br_taken_q, .irq_take_q, .nmi_take_q);

    // ----------------------------------------------------------------
    // Clock, watchdog, reporting
    // ----------------------------------------------------------------
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            report_and_stop();
        end
    end

    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Expected-value functions
    // ----------------------------------------------------------------
    function automatic logic [31:0] view(logic [31:0] r, crf_sel_t v);
        if (v.size == SZ_LONG) return r;
        if (v.size == SZ_WORD) return v.part ? r[31:16] : r[15:0];
        return v.part ? r[15:8] : r[7:0];
    endfunction

    function automatic logic [31:0] merge(logic [31:0] r, crf_sel_t v, logic [31:0] x);
        if (v.size == SZ_LONG) r = x;
        else if (v.size == SZ_WORD && v.part) r[31:16] = x[15:0];
        else if (v.size == SZ_WORD) r[15:0] = x[15:0];
        else if (v.part) r[15:8] = x[7:0];
        else r[7:0] = x[7:0];
        return r;
    endfunction

    function automatic logic [7:0] arith(crf_alu_t x, logic ci);
        int w;
        logic [31:0] m, hm, a, b;
        logic [33:0] r, h;
        logic sub, sa, sr;
        w = x.size == SZ_BYTE ? 8 : x.size == SZ_WORD ? 16 : 32;
        m = `CRF_L_MASK >> (32 - w);
        hm = m >> 4;
        a = x.kind == ALU_NEG ? 32'h0000_0000 : x.a & m;
        b = (x.kind == ALU_NEG ? x.a : x.b) & m;
        ci = ci & (x.kind inside {ALU_ADDX, ALU_SUBX});
        sub = x.kind inside {ALU_SUB, ALU_SUBX, ALU_CMP, ALU_NEG};
        r = sub ? a - b - ci : a + b + ci;
        h = sub ? (a & hm) - (b & hm) - ci : (a & hm) + (b & hm) + ci;
        sa = a[w-1];
        sr = r[w-1];
        if (x.kind == ALU_LOGIC) return {4'h0, a[w-1], a == 32'h0000_0000, 2'b00};
        return {2'b00, h[w-4], 1'b0, sr, (r[31:0] & m) == 32'h0000_0000,
            (sa ^ sr) & (sub ? sa ^ b[w-1] : ~(sa ^ b[w-1])), r[w]};
    endfunction

    function automatic logic taken(crf_br_cond_t c, logic [7:0] f);
        logic [7:0] tb;
        tb = {~f[2] & (f[3] ~^ f[1]), f[3] ~^ f[1], ~f[3], ~f[1], ~f[2], ~f[0], ~(f[0] | f[2]), 1'b1};
        return tb[c[3:1]] ^ c[0];
    endfunction

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'he69a));
        foreach (regs[i]) regs[i] = `CRF_REG_RST;
        fl = `CRF_FLAGS_RST;
        pc_e = `CRF_PC_RST;
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        rstn = 1'b1;
        chk("flags", flags_q, fl);
        chk("pc", pc_q, pc_e);
        for (int i = 0; i < 60; i++) begin
            s = 6'($urandom);
            s.size = crf_size_t'($urandom_range(2));
            t = 6'($urandom);
            t.size = crf_size_t'($urandom_range(2));
            d = $urandom;
            crf_core_model_i.nx.wr = '{1'b1, s, d};
            crf_core_model_i.step();
            regs[s.idx] = merge(regs[s.idx], s, d);
            crf_core_model_i.nx.ra = s;
            crf_core_model_i.nx.rb = t;
            crf_core_model_i.step();
            chk("rd_a", rd_a_q, view(regs[s.idx], s));
            chk("rd_b", rd_b_q, view(regs[t.idx], t));
            chk("sp", sp_q, regs[7]);
        end
        for (k = 1; k < 5; k++) begin
            crf_core_model_i.nx.sp = crf_sp_cmd_t'(k);
            crf_core_model_i.step();
            d = (k % 2) ? `CRF_SP_W_STEP : `CRF_SP_L_STEP;
            regs[7] = (k > 2) ? regs[7] + d : regs[7] - d;
            chk("sp", sp_q, regs[7]);
            chk("sp_addr", sp_addr_q, regs[7][15:0]);
        end
        for (int i = 0; i < 12; i++) begin
            k = i == 0 ? 3 : $urandom_range(3, 1);
            crf_core_model_i.nx.pc = crf_pc_cmd_t'(k);
            crf_core_model_i.nx.pv = i == 0 ? 24'h00_1235 : 24'($urandom);
            pc_e = k == 1 ? pc_e + `CRF_PC_STEP : crf_core_model_i.nx.pv;
            crf_core_model_i.step();
            chk("pc", pc_q, pc_e);
            chk("fetch", fetch_addr_q, {pc_e[15:1], 1'b0});
        end
        for (int i = 0; i < 16; i++) begin
            e = 8'($urandom);
            k = $urandom_range(4, 1);
            crf_core_model_i.nx.fr = '{crf_flag_op_t'(k), e, 8'h00};
            crf_core_model_i.nx.exc = i[0];
            fl = k == 1 ? e : k == 2 ? fl & e : k == 3 ? fl | e : fl ^ e;
            fl[7] = fl[7] | i[0];
            crf_core_model_i.step();
            chk("flags", flags_q, fl);
            chk("pc", pc_q, pc_e);
        end
        for (int i = 0; i < 80; i++) begin
            al = '{crf_alu_kind_t'($urandom_range(6)), crf_size_t'($urandom_range(2)), $urandom, $urandom};
            if (i % 4 == 0) al.b = al.a;
            e = 8'($urandom) & 8'hef;
            if (i == 0) begin
                al = '{ALU_SUB, SZ_BYTE, 32'h0000_0000, 32'h0000_0001};
                e = 8'h2f;
            end
            crf_core_model_i.nx.alu = al;
            crf_core_model_i.nx.fr = '{FL_ARITH, 8'h00, e};
            d = al.kind inside {[ALU_SUB:ALU_CMP]} ? al.a - al.b - (al.kind == ALU_SUBX & fl[0]) : al.a + al.b;
            d = al.kind == ALU_NEG ? -al.a : al.kind == ALU_LOGIC ? al.a : d + (al.kind == ALU_ADDX & fl[0]);
            fl = (fl & ~(e & 8'h2f)) | (arith(al, fl[0]) & e);
            crf_core_model_i.step();
            chk("flags", flags_q, fl);
            chk("alu_res", alu_res_q, d);
        end
        for (int i = 0; i < 32; i++) begin
            fl = 8'($urandom);
            crf_core_model_i.nx.fr = '{FL_LOAD, fl, 8'h00};
            crf_core_model_i.step();
            e = 8'($urandom);
            crf_core_model_i.nx.br = crf_br_cond_t'(i % 16);
            crf_core_model_i.nx.irq = e[0];
            crf_core_model_i.nx.nmi = e[1];
            crf_core_model_i.step();
            chk("branch", br_taken_q, taken(crf_br_cond_t'(i % 16), fl));
            chk("irq", irq_take_q, e[0] & ~fl[7]);
            chk("nmi", nmi_take_q, e[1]);
        end
        report_and_stop();
    end
endmodule // test_cpu_register_set_and_flags
